// File: src/azbd_decider.sv
// azbd_decider.sv: zone decision logic turning per-period zone results into backlight targets
// assumes: one 40 MHz clock; sample and period_tick come synchronous from the averager;
// the host reads registers over apb and watches the open-drain interrupt pin
`timescale 1ns/1ps
`include "azbd_map.svh"

// Function
// [RULE1] direct mode moves target up or down
// [RULE2] enable starts three fast 1.1ms periods
// [RULE3] keep running zone and averager output zone
// [RULE4] switch on third consecutive period moved
// [RULE5] same-direction change after forcing switches at once
// [RULE6] opposite change keeps target, restarts qualification
// [RULE7] down-delay mode adds periods for downward moves
// [RULE8] extra periods equal code plus three
// [RULE9] rise before delay ends cancels lowering
// [RULE10] delay counts from first drop, applied at boundary
// [RULE11] new zone pulls interrupt pin low
// [RULE12] same moment loads zone info, sets flag
// [RULE13] reading zone info clears flag, releases pin
// [RULE14] target changes only at period start
// [RULE15] startup zone state defaults to zone zero
// [RULE16] boundaries use separate high and low thresholds
// [RULE17] algorithm select takes effect at next boundary
module azbd_decider #(
  parameter int unsigned FAST_CYCLES = (`AZBD_FAST_NS * 1000) / (`AZBD_CLK_NS * 1000)  // cycles per fast period
) (
  input  wire logic                     pclk,          // 40 MHz clock
  input  wire logic                     presetn,       // async reset, active low
  input  wire azbd_pkg::azbd_apb_req_type apb_req,     // apb request group
  output azbd_pkg::azbd_apb_rsp_type    apb_rsp,       // apb answer group
  input  wire logic                     sample_valid,  // averaged sample strobe
  input  wire logic [7:0]               sample,        // light_sensor_input level
  input  wire logic                     period_tick,   // end of a normal average period
  output logic [2:0]                    target_zone,   // zone whose target is selected
  output logic                          target_update, // pulse when target changes
  output logic                          int_out,       // interrupt pin drive level
  output logic                          int_oe,        // high while pin is pulled low
  output logic                          irq            // level interrupt to host
);

  localparam logic [15:0] FAST_LAST = 16'(FAST_CYCLES - 1);  // last cycle of a fast period

  azbd_pkg::azbd_state_type cur;   // registered state
  azbd_pkg::azbd_state_type next_state;  // next state

  // zone of a sample with hysteresis around the present zone
  function automatic logic [2:0] zone_of(input logic [7:0] s, input logic [2:0] z_now,
                                         input logic [31:0] hi, input logic [31:0] lo);
    logic [2:0] z;
    z = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < z_now) begin
        if (s >= lo[8*i +: 8]) z = z + 3'h1;  // stay above until falling threshold
      end else begin
        if (s > hi[8*i +: 8]) z = z + 3'h1;   // cross only past rising threshold
      end
    end
    return z;
  endfunction

  // address match on the word offset
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr[7:2] == off[7:2];
  endfunction

  // derived bus strobes
  logic setup_ph;   // first cycle of a transfer
  logic access_ph;  // completing cycle, pready is always high
  logic wr_en;      // write commits
  logic rd_info;    // zone info read completes
  logic boundary;   // start of a new average period
  logic [2:0] new_run;  // running zone after this sample

  assign setup_ph  = apb_req.psel && !apb_req.penable;
  assign access_ph = apb_req.psel && apb_req.penable;
  assign wr_en     = access_ph && apb_req.pwrite;
  assign rd_info   = access_ph && !apb_req.pwrite && hit(apb_req.paddr, `AZBD_OFF_ZONE_INFO);  // RULE13
  assign boundary  = (cur.phase == azbd_pkg::PH_FAST) ? (cur.fast_cnt == FAST_LAST)  // RULE2
                   : (cur.phase == azbd_pkg::PH_RUN) && period_tick;                  // RULE14
  assign new_run   = zone_of(sample, cur.running_zone, cur.bnd_hi, cur.bnd_lo);       // RULE16

  // next-state logic: bus, zone tracking, decision and interrupt
  always_comb begin
    logic [5:0]           need;      // periods required for this move
    azbd_pkg::azbd_dir_type d_ref;   // direction from the starting zone
    azbd_pkg::azbd_dir_type d_chg;   // direction of this period's change
    logic [2:0]           avg_new;   // averager output for the new period
    logic [1:0]           ev;        // events this cycle
    next_state = cur;
    need    = `AZBD_BASE_QUAL;
    d_ref   = azbd_pkg::DIR_NONE;
    d_chg   = azbd_pkg::DIR_NONE;
    avg_new = cur.running_zone;
    ev      = 2'h0;
    next_state.target_pulse = 1'b0;

    // register writes
    if (wr_en) begin
      if (hit(apb_req.paddr, `AZBD_OFF_CTRL)) begin
        next_state.ctrl_enable = apb_req.pwdata[`AZBD_CTRL_ENABLE];
        next_state.ctrl_mode   = apb_req.pwdata[`AZBD_CTRL_MODE];  // RULE17
        next_state.ctrl_code   = apb_req.pwdata[`AZBD_CTRL_CODE_LSB +: 5];
      end
      if (hit(apb_req.paddr, `AZBD_OFF_IRQ_MASK)) next_state.irq_mask = apb_req.pwdata[1:0];
      if (hit(apb_req.paddr, `AZBD_OFF_BND_HI))   next_state.bnd_hi   = apb_req.pwdata;
      if (hit(apb_req.paddr, `AZBD_OFF_BND_LO))   next_state.bnd_lo   = apb_req.pwdata;
      if (hit(apb_req.paddr, `AZBD_OFF_IRQ_STAT)) next_state.irq_status = cur.irq_status & ~apb_req.pwdata[1:0];
    end

    // read data latched in setup so it stands through the access phase
    if (setup_ph) begin
      next_state.pslverr = 1'b0;
      next_state.prdata  = 32'h0;
      // byte offset bits masked so the decode matches hit() on the word offset
      case (apb_req.paddr & 8'hFC)
        `AZBD_OFF_CTRL:      next_state.prdata = {25'h0, cur.ctrl_code, cur.ctrl_mode, cur.ctrl_enable};
        `AZBD_OFF_ZONE_INFO: next_state.prdata = {28'h0, cur.info_flag, cur.info_zone};
        `AZBD_OFF_STATE:     next_state.prdata = {12'h0, cur.qual_cnt, cur.phase, 1'b0, cur.running_zone,
                                                 1'b0, cur.avg_zone, 1'b0, cur.target_zone};
        `AZBD_OFF_IRQ_STAT:  next_state.prdata = {30'h0, cur.irq_status};
        `AZBD_OFF_IRQ_MASK:  next_state.prdata = {30'h0, cur.irq_mask};
        `AZBD_OFF_BND_HI:    next_state.prdata = cur.bnd_hi;
        `AZBD_OFF_BND_LO:    next_state.prdata = cur.bnd_lo;
        default:                  next_state.pslverr = 1'b1;  // unmapped address
      endcase
    end

    // acknowledge read releases the pin; a new event below wins
    if (rd_info) begin
      next_state.info_flag = 1'b0;  // RULE13
      next_state.int_drive = 1'b0;  // RULE13
    end

    // sensing phase machine
    case (cur.phase)
      azbd_pkg::PH_OFF: begin
        if (cur.ctrl_enable) begin
          next_state.phase        = azbd_pkg::PH_FAST;     // RULE2
          next_state.fast_left    = `AZBD_FAST_PERIODS;    // RULE2
          next_state.fast_cnt     = 16'h0;
          next_state.running_zone = 3'h0;                  // RULE15
          next_state.avg_zone     = 3'h0;                  // RULE15
          next_state.ref_zone     = 3'h0;                  // RULE15
          next_state.dir          = azbd_pkg::DIR_NONE;
          next_state.qual_cnt     = 6'h0;
          next_state.chain        = 1'b0;
          next_state.mode_dd      = cur.ctrl_mode;
        end
      end
      azbd_pkg::PH_FAST, azbd_pkg::PH_RUN: begin
        if (!cur.ctrl_enable) begin
          next_state.phase     = azbd_pkg::PH_OFF;
          next_state.int_drive = 1'b0;  // pin only pulls while sensing
        end else begin
          // running zone follows every sample
          if (sample_valid && new_run != cur.running_zone) begin
            next_state.running_zone = new_run;  // RULE3
            next_state.info_zone    = new_run;  // RULE12
            next_state.info_flag    = 1'b1;     // RULE12
            next_state.int_drive    = 1'b1;     // RULE11
            ev[`AZBD_IRQ_ZONE]      = 1'b1;
          end
          if (cur.phase == azbd_pkg::PH_FAST) begin
            next_state.fast_cnt = (boundary) ? 16'h0 : cur.fast_cnt + 16'h1;
          end
          // decisions happen only at a period start
          if (boundary) begin
            next_state.avg_zone = avg_new;  // RULE3
            next_state.mode_dd  = cur.ctrl_mode;  // RULE17
            if (cur.phase == azbd_pkg::PH_FAST) begin
              // fast startup: target tracks the averager directly
              if (avg_new != cur.target_zone) begin
                next_state.target_zone  = avg_new;
                next_state.target_pulse = 1'b1;
                ev[`AZBD_IRQ_TARGET]    = 1'b1;
              end
              next_state.ref_zone  = avg_new;
              next_state.fast_left = cur.fast_left - 2'h1;
              if (cur.fast_left == 2'h1) next_state.phase = azbd_pkg::PH_RUN;
            end else begin
              if (avg_new > cur.avg_zone) d_chg = azbd_pkg::DIR_UP;
              else if (avg_new < cur.avg_zone) d_chg = azbd_pkg::DIR_DOWN;
              if (avg_new > cur.ref_zone) d_ref = azbd_pkg::DIR_UP;
              else if (avg_new < cur.ref_zone) d_ref = azbd_pkg::DIR_DOWN;
              // extra periods for falls in down-delay mode
              if (cur.mode_dd && d_ref == azbd_pkg::DIR_DOWN) begin
                need = `AZBD_BASE_QUAL + `AZBD_DD_OFFSET + {1'b0, cur.ctrl_code};  // RULE7 RULE8
              end
              next_state.chain = 1'b0;
              if (cur.chain && d_chg != azbd_pkg::DIR_NONE && d_chg == cur.dir
                  && !(cur.mode_dd && d_chg == azbd_pkg::DIR_DOWN)) begin
                // follow-on move right after a forced change
                next_state.target_zone  = avg_new;  // RULE5
                next_state.ref_zone     = avg_new;
                next_state.chain        = 1'b1;
                next_state.qual_cnt     = 6'h0;
                next_state.target_pulse = 1'b1;
                ev[`AZBD_IRQ_TARGET]    = 1'b1;
              end else if (d_ref == azbd_pkg::DIR_NONE) begin
                // back at the starting zone, nothing to qualify
                next_state.dir      = azbd_pkg::DIR_NONE;
                next_state.qual_cnt = 6'h0;
              end else if (d_ref != cur.dir ||
                           (d_chg != azbd_pkg::DIR_NONE && d_chg != cur.dir)) begin
                // reversal: keep target and count again from this change
                next_state.dir      = d_ref;   // RULE6 RULE9
                next_state.qual_cnt = 6'h1;    // RULE6 RULE10
              end else if (cur.qual_cnt + 6'h1 >= need) begin
                // qualified: apply averager zone's target now
                next_state.target_zone  = avg_new;  // RULE1 RULE4 RULE10 RULE14
                next_state.ref_zone     = avg_new;
                next_state.chain        = 1'b1;
                next_state.qual_cnt     = 6'h0;
                next_state.target_pulse = 1'b1;
                ev[`AZBD_IRQ_TARGET]    = 1'b1;
              end else begin
                next_state.qual_cnt = cur.qual_cnt + 6'h1;  // RULE4
              end
            end
          end
        end
      end
      default: next_state.phase = azbd_pkg::PH_OFF;
    endcase

    // sticky events: a set wins over a same-cycle clear
    next_state.irq_status = next_state.irq_status | ev;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur              <= '0;
      cur.phase        <= azbd_pkg::PH_OFF;
      cur.dir          <= azbd_pkg::DIR_NONE;
      cur.bnd_hi       <= `AZBD_RST_BND_HI;
      cur.bnd_lo       <= `AZBD_RST_BND_LO;
      cur.irq_mask     <= `AZBD_RST_IRQ_MASK;
    end else begin
      cur <= next_state;
    end
  end

  // outputs
  assign apb_rsp.pready  = 1'b1;  // zero-wait slave
  assign apb_rsp.pslverr = cur.pslverr && access_ph;
  assign apb_rsp.prdata  = cur.prdata;
  assign target_zone     = cur.target_zone;
  assign target_update   = cur.target_pulse;
  assign int_out         = 1'b0;           // open drain only ever pulls low
  assign int_oe          = cur.int_drive;  // RULE11
  assign irq             = |(cur.irq_status & cur.irq_mask);

endmodule // azbd_decider

// File: src/azbd_map.svh
// azbd_map.svh: register offsets, field positions, reset values and timing counts
// assumes: included by bare name; byte offsets on a 32-bit apb bus
`ifndef AZBD_MAP_SVH
`define AZBD_MAP_SVH

// register byte offsets
`define AZBD_OFF_CTRL      8'h00
`define AZBD_OFF_ZONE_INFO 8'h04
`define AZBD_OFF_STATE     8'h08
`define AZBD_OFF_IRQ_STAT  8'h0C
`define AZBD_OFF_IRQ_MASK  8'h10
`define AZBD_OFF_BND_HI    8'h14
`define AZBD_OFF_BND_LO    8'h18

// field positions
`define AZBD_CTRL_ENABLE   0
`define AZBD_CTRL_MODE     1
`define AZBD_CTRL_CODE_LSB 2
`define AZBD_INFO_FLAG     3
`define AZBD_IRQ_ZONE      0
`define AZBD_IRQ_TARGET    1

// reset values
`define AZBD_RST_BND_HI    32'hCC996633
`define AZBD_RST_BND_LO    32'hC4915E2B
`define AZBD_RST_IRQ_MASK  2'h0

// timing and counts
`define AZBD_CLK_NS        25
`define AZBD_FAST_NS       1100000
`define AZBD_FAST_PERIODS  2'h3
`define AZBD_BASE_QUAL     6'h03
`define AZBD_DD_OFFSET     6'h03

`endif

// File: src/azbd_pkg.sv
// azbd_pkg.sv: types of the ambient zone backlight decider
// assumes: constants come from azbd_map.svh, nothing else is shared
package azbd_pkg;

  typedef enum logic [1:0] {PH_OFF, PH_FAST, PH_RUN} azbd_phase_type;   // sensing phase
  typedef enum logic [1:0] {DIR_NONE, DIR_UP, DIR_DOWN} azbd_dir_type;  // direction of a move

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } azbd_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } azbd_apb_rsp_type;

  typedef struct packed {
    logic           ctrl_enable;   // sensing enabled
    logic           ctrl_mode;     // 1 selects down-delay
    logic [4:0]     ctrl_code;     // down-delay code
    logic [31:0]    bnd_hi;        // rising thresholds, byte per boundary
    logic [31:0]    bnd_lo;        // falling thresholds
    logic [1:0]     irq_status;    // sticky events
    logic [1:0]     irq_mask;      // event enables
    azbd_phase_type phase;
    logic [1:0]     fast_left;     // fast periods still to run
    logic [15:0]    fast_cnt;      // cycles within a fast period
    logic [2:0]     running_zone;  // zone of period in progress
    logic [2:0]     avg_zone;      // zone of last full period
    logic [2:0]     target_zone;   // zone whose target drives the led
    logic [2:0]     ref_zone;      // starting zone of qualification
    azbd_dir_type   dir;           // direction being qualified
    logic [5:0]     qual_cnt;      // qualifying periods seen
    logic           chain;         // a forced change just happened
    logic           mode_dd;       // algorithm in force this period
    logic [2:0]     info_zone;     // zone information register
    logic           info_flag;     // software flag
    logic           int_drive;     // interrupt pin pulled low
    logic           target_pulse;  // one cycle on a target change
    logic [31:0]    prdata;        // read data latched at setup
    logic           pslverr;       // unmapped address seen at setup
  } azbd_state_type;

endpackage

// File: testbench/azbd_host_pin.sv
// azbd_host_pin.sv: host side of the open-drain interrupt line
// assumes: pull-up on the board, host acknowledges by reading zone info
`timescale 1ns/1ps
module azbd_host_pin (
  input  wire logic int_out,  // level driven while enabled
  input  wire logic int_oe,   // device pulls the line
  output wire logic int_line  // level the host sees
);
  // released line floats to the pull-up, never to a stale value
  assign int_line = int_oe ? int_out : 1'h1;
endmodule // azbd_host_pin

// File: testbench/azbd_decider_sva.sv
// azbd_decider_sva.sv: port checker of the zone decider
// assumes: one clock domain, bound into every azbd_decider
`timescale 1ns/1ps
module azbd_decider_sva (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire azbd_pkg::azbd_apb_req_type apb_req,
  input wire azbd_pkg::azbd_apb_rsp_type apb_rsp,
  input wire logic                       sample_valid,
  input wire logic [7:0]                 sample,
  input wire logic                       period_tick,
  input wire logic [2:0]                 target_zone,
  input wire logic                       target_update,
  input wire logic                       int_out,
  input wire logic                       int_oe,
  input wire logic                       irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;      // access phase of a transfer
  logic info_rd;  // zone info read completing
  assign acc     = apb_req.psel && apb_req.penable;
  assign info_rd = acc && !apb_req.pwrite && apb_req.paddr[7:2] == 6'h01;
  // bus answers
  chk_ready_high: assert property (apb_rsp.pready) else $error("pready low");
  chk_unmapped_err: assert property (acc && apb_req.paddr[7:2] > 6'h06 |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (acc && apb_req.paddr[7:2] <= 6'h06 |-> !apb_rsp.pslverr)
    else $error("mapped access refused");
  // interrupt pin
  chk_pin_low: assert property (int_oe |-> !int_out) else $error("pin not pulled low");
  chk_int_cause: assert property ($rose(int_oe) |-> $past(sample_valid))
    else $error("interrupt without a sample");
  chk_flag_read: assert property (info_rd |-> apb_rsp.prdata[3] == $past(int_oe))
    else $error("flag differs from pin");
  chk_read_release: assert property (info_rd && !sample_valid && !$past(sample_valid) |=> !int_oe)
    else $error("pin held after read");
  // target changes
  chk_target_pulse: assert property ($changed(target_zone) |-> target_update)
    else $error("target moved without pulse");
  chk_pulse_cause: assert property (target_update |-> $changed(target_zone))
    else $error("pulse without target move");
  cover property ($rose(int_oe));
  cover property (target_update);
  cover property (info_rd);
  cover property (acc && apb_rsp.pslverr);
endmodule // azbd_decider_sva

bind azbd_decider azbd_decider_sva chk (.pclk, .presetn, .apb_req, .apb_rsp, .sample_valid, .sample,
  .period_tick, .target_zone, .target_update, .int_out, .int_oe, .irq);

// File: testbench/azbd_decider_tb.sv
// azbd_decider_tb.sv: self-checking bench of the zone decider
// assumes: checker bound by azbd_decider_sva.sv, fast period shortened
`timescale 1ns/1ps
`include "azbd_map.svh"
module azbd_decider_tb;
  localparam int unsigned FC = 20;                  // short fast period
  logic                       pclk = 1'h0;          // 40 MHz clock
  logic                       presetn = 1'h0;       // reset, active low
  azbd_pkg::azbd_apb_req_type apb_req = '0;         // bus request
  azbd_pkg::azbd_apb_rsp_type apb_rsp;              // bus answer
  logic                       sample_valid = 1'h0;  // sample strobe
  logic [7:0]                 sample = 8'h00;       // light level
  logic                       period_tick = 1'h0;   // period boundary
  logic [2:0]                 target_zone;          // selected zone
  logic                       target_update;        // change pulse
  logic                       int_out;              // pin drive level
  logic                       int_oe;               // pin enable
  logic                       irq;                  // host interrupt
  logic                       int_line;             // resolved pin
  logic [31:0]                rd;                   // last read data
  logic                       err;                  // last slave error
  int                         miscompares = 0;      // mismatches
  int                         n_checks = 0;         // comparisons
  // levels well clear of every hysteresis band
  logic [7:0]                 lvl [5] = '{8'h10, 8'h50, 8'h80, 8'hB0, 8'hF0};

  always #12.5 pclk = ~pclk;

  azbd_decider #(.FAST_CYCLES(FC)) DUT (.pclk, .presetn, .apb_req, .apb_rsp, .sample_valid, .sample,
    .period_tick, .target_zone, .target_update, .int_out, .int_oe, .irq);
  azbd_host_pin host (.int_out, .int_oe, .int_line);

  // compare and count
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, got);
    end
  endtask

  // one apb transfer, waits for pready however long it takes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'h1;
    @(posedge pclk);
    // only the watchdog ends a wait for the answer
    while (apb_rsp.pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'h0;
    apb_req.penable <= 1'h0;
  endtask

  // hold a level long enough for a multi-zone move
  task automatic set_zone(input int z);
    @(posedge pclk);
    sample <= lvl[z];
    sample_valid <= 1'h1;
    repeat (3) @(posedge pclk);
    sample_valid <= 1'h0;
  endtask

  // n period boundaries, one-cycle pulses with gaps
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      period_tick <= 1'h1;
      @(posedge pclk);
      period_tick <= 1'h0;
      repeat (3) @(posedge pclk);
    end
  endtask

  task automatic t_reset();
    apb(1'h0, `AZBD_OFF_BND_HI, 32'h0);
    check("bnd_hi", `AZBD_RST_BND_HI, rd);
    apb(1'h0, `AZBD_OFF_BND_LO, 32'h0);
    check("bnd_lo", `AZBD_RST_BND_LO, rd);
    apb(1'h0, `AZBD_OFF_IRQ_MASK, 32'h0);
    check("irq_mask", 32'h0, rd);
    apb(1'h0, 8'h40, 32'h0);
    check("unmapped_err", 32'h1, 32'(err));
    check("unmapped_data", 32'h0, rd);
    check("target_reset", 32'h0, 32'(target_zone));
    $display("test reset done");
  endtask

  // enable, zone event, acknowledge, fast startup
  task automatic t_startup();
    apb(1'h1, `AZBD_OFF_IRQ_MASK, 32'h1);
    apb(1'h1, `AZBD_OFF_CTRL, 32'h1);
    set_zone(2);
    check("pin_low", 32'h0, 32'(int_line));
    check("irq_set", 32'h1, 32'(irq));
    check("target_early", 32'h0, 32'(target_zone));
    apb(1'h0, `AZBD_OFF_ZONE_INFO, 32'h0);
    check("zone_info", 32'h0000000A, rd);
    @(posedge pclk);
    check("pin_released", 32'h1, 32'(int_line));
    apb(1'h1, `AZBD_OFF_IRQ_STAT, 32'h3);
    @(posedge pclk);
    check("irq_cleared", 32'h0, 32'(irq));
    repeat (3 * FC + 10) @(posedge pclk);
    check("target_fast", 32'h2, 32'(target_zone));
    $display("test startup done");
  endtask

  // qualification, chained move, reversal, plain drop
  task automatic t_direct();
    set_zone(3);
    tick(2);
    check("target_q2", 32'h2, 32'(target_zone));
    tick(1);
    check("target_q3", 32'h3, 32'(target_zone));
    set_zone(4);
    tick(1);
    check("target_chain", 32'h4, 32'(target_zone));
    set_zone(3);
    tick(1);
    check("target_hold", 32'h4, 32'(target_zone));
    set_zone(4);
    tick(1);
    check("target_reverse", 32'h4, 32'(target_zone));
    set_zone(3);
    tick(2);
    check("target_restart", 32'h4, 32'(target_zone));
    tick(1);
    check("target_down", 32'h3, 32'(target_zone));
    $display("test direct done");
  endtask

  // down-delay code 0: six periods down, rise cancels
  task automatic t_delay();
    apb(1'h1, `AZBD_OFF_CTRL, 32'h3);
    tick(1);
    set_zone(2);
    tick(5);
    check("target_wait", 32'h3, 32'(target_zone));
    tick(1);
    check("target_low", 32'h2, 32'(target_zone));
    set_zone(1);
    tick(3);
    set_zone(2);
    tick(1);
    check("rise_keeps", 32'h2, 32'(target_zone));
    // a count that survived the rise would drop the target early here
    set_zone(1);
    repeat (5) begin
      tick(1);
      check("never_lower", 32'h2, 32'(target_zone));
    end
    tick(1);
    check("late_low", 32'h1, 32'(target_zone));
    $display("test delay done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog well above the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    $display("unexpected watchdog: expected done seen hang");
    print_verdict();
  end

  // main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_startup();
    t_direct();
    t_delay();
    print_verdict();
  end
endmodule // azbd_decider_tb
